// *** swg_global_regs.sv ***
// Purpose: Global control slice: storm rate low byte, factory test bytes, reduced-MII edge and power save
// Assumes: Management register port with one-cycle wr/rd strobes, synchronous to clk
// Notes:   Read data is registered and valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "swg_map.svh"

module swg_global_regs #(
    parameter int NUM_PORTS = 4,
    parameter int CNT_W     = 24,
    parameter int P100_CYC  = `SWG_PERIOD_100M_CYC,
    parameter int P10_CYC   = `SWG_PERIOD_10M_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire swg_pkg::swg_reg_req_t reg_req,
    output logic [7:0]                rd_data,
    output logic                      rd_valid,
    input  wire logic [2:0]           storm_rate_hi,
    input  wire logic [NUM_PORTS-1:0] port_10m,
    input  wire logic [NUM_PORTS-1:0] bcast_block_req,
    output logic [NUM_PORTS-1:0]      bcast_block_admit,
    output logic [NUM_PORTS-1:0]      bcast_block_drop,
    output swg_pkg::swg_ctrl_t        ctrl
);

    logic [7:0] storm_low_r;
    logic [7:0] edge_psave_r;
    logic [7:0] rd_data_r;
    logic       rd_valid_r;
    logic [7:0] edge_psave_nxt;
    logic [7:0] rd_mux;
    logic [10:0] threshold;

    // Address decode
    wire hit_storm  = reg_req.addr == `SWG_OFS_STORM_LOW;
    wire hit_fa     = reg_req.addr == `SWG_OFS_FACTORY_A;
    wire hit_fb     = reg_req.addr == `SWG_OFS_FACTORY_B;
    wire hit_fc     = reg_req.addr == `SWG_OFS_FACTORY_C;
    wire hit_edge   = reg_req.addr == `SWG_OFS_EDGE_PSAVE;
    wire hit_any    = hit_storm || hit_fa || hit_fb || hit_fc || hit_edge;
    wire wr_storm   = reg_req.wr && hit_storm;
    wire wr_edge    = reg_req.wr && hit_edge;

    // reserved bits stay fixed
    // Only bits 7, 6 and 3 take write data; the rest keep their reset value
    assign edge_psave_nxt = {reg_req.wdata[`SWG_BIT_P3_FALL], reg_req.wdata[`SWG_BIT_P4_FALL],
                             2'h0, reg_req.wdata[`SWG_BIT_PSAVE_DIS], 3'h0};

    assign threshold = {storm_rate_hi, storm_low_r};

    // read mux: two registers and fixed values
    // Factory bytes are constants in the mux, so no write can reach them
    assign rd_mux = hit_storm ? storm_low_r :
                    hit_fa    ? `SWG_RST_FACTORY_A :
                    hit_fb    ? `SWG_RST_FACTORY_B :
                    hit_fc    ? `SWG_RST_FACTORY_C :
                    hit_edge  ? edge_psave_r :
                                `SWG_RD_UNMAPPED;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            storm_low_r <= `SWG_RST_STORM_LOW;
        else if (wr_storm)
            storm_low_r <= reg_req.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            edge_psave_r <= `SWG_RST_EDGE_PSAVE;
        else if (wr_edge)
            edge_psave_r <= edge_psave_nxt;
    end

    // Registered read port; a read and a write in one cycle return the old value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rd_data_r  <= 8'h00;
            rd_valid_r <= 1'b0;
        end
        else
        begin
            rd_valid_r <= reg_req.rd;
            if (reg_req.rd)
                rd_data_r <= rd_mux;
        end
    end

    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;

    assign ctrl.port3_reduced_mii_fall = edge_psave_r[`SWG_BIT_P3_FALL];
    assign ctrl.port4_reduced_mii_fall = edge_psave_r[`SWG_BIT_P4_FALL];
    assign ctrl.phy_power_save_dis     = edge_psave_r[`SWG_BIT_PSAVE_DIS];
    assign ctrl.storm_threshold        = threshold;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++)
        begin : g_meter
            swg_storm_meter #(
                .CNT_W (CNT_W),
                .P100  (P100_CYC),
                .P10   (P10_CYC)
            ) u_meter (
                .clk         (clk),
                .rst_n       (rst_n),
                .port_10m    (port_10m[gi]),
                .threshold   (threshold),
                .block_req   (bcast_block_req[gi]),
                .block_admit (bcast_block_admit[gi]),
                .block_drop  (bcast_block_drop[gi])
            );
        end
    endgenerate

    // Read request sequence used by several checks
    sequence rd_of(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence

    low_reset_a: assert property (@(posedge clk)
        !rst_n |=> storm_low_r == `SWG_RST_STORM_LOW && threshold[7:0] == 8'h4A)
        else $error("storm low byte reset value wrong");

    low_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_storm |=> threshold == {storm_rate_hi, $past(reg_req.wdata)} || $changed(storm_rate_hi))
        else $error("threshold does not follow low byte write");

    p3_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_edge |=> ctrl.port3_reduced_mii_fall == $past(reg_req.wdata[7]))
        else $error("third MAC edge select not written");

    p4_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_edge |=> ctrl.port4_reduced_mii_fall == $past(reg_req.wdata[6]))
        else $error("fourth MAC edge select not written");

    psave_dis_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_edge && !ctrl.phy_power_save_dis |=> !ctrl.phy_power_save_dis)
        else $error("power save disable set without a write");

    factory_b_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`SWG_OFS_FACTORY_B) |=> rd_valid && rd_data == 8'h4C)
        else $error("factory byte B read wrong");

    reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`SWG_OFS_EDGE_PSAVE) |=> (rd_data & 8'h37) == 8'h00)
        else $error("reserved bits read nonzero");

    // Read answer one cycle after the strobe
    sequence rd_ans(logic [7:0] d);
        rd_valid && rd_data == d;
    endsequence

    psave_reset_a: assert property (@(posedge clk)
        !rst_n |=> !ctrl.phy_power_save_dis)
        else $error("power save disable not cleared by reset");

    edge_reset_a: assert property (@(posedge clk)
        !rst_n |=> !ctrl.port3_reduced_mii_fall && !ctrl.port4_reduced_mii_fall)
        else $error("edge selects not cleared by reset");

    psave_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_edge |=> ctrl.phy_power_save_dis == $past(reg_req.wdata[`SWG_BIT_PSAVE_DIS]))
        else $error("power save disable not written");

    // low byte and edge register hold
    // Antecedent samples rst_n so a reset edge is not taken for a stray change
    storm_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !wr_storm |=> storm_low_r == $past(storm_low_r))
        else $error("storm low byte changed without a write");

    edge_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !wr_edge |=> edge_psave_r == $past(edge_psave_r))
        else $error("edge register changed without a write");

    reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        edge_psave_r[5:4] == 2'h0 && edge_psave_r[2:0] == 3'h0)
        else $error("reserved bits of edge register set");

    factory_a_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`SWG_OFS_FACTORY_A) |=> rd_ans(`SWG_RST_FACTORY_A))
        else $error("factory byte A read wrong");

    factory_c_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`SWG_OFS_FACTORY_C) |=> rd_ans(`SWG_RST_FACTORY_C))
        else $error("factory byte C read wrong");

    unmapped_a: assert property (@(posedge clk) disable iff (!rst_n)
        reg_req.rd && !hit_any |=> rd_ans(`SWG_RD_UNMAPPED))
        else $error("unmapped read not zero");

    storm_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        rd_of(`SWG_OFS_STORM_LOW) |=> rd_valid && rd_data == $past(storm_low_r))
        else $error("storm low byte read wrong");

endmodule : swg_global_regs

`default_nettype wire

// *** swg_map.svh ***
// Purpose: Offsets, reset values, field positions and timing counts of the global control slice
// Assumes: 8-bit management register port, 25 MHz core clock
// Notes:   Definitions only
`ifndef SWG_MAP_SVH
`define SWG_MAP_SVH

// Register offsets
`define SWG_OFS_STORM_LOW      8'h07
`define SWG_OFS_FACTORY_A      8'h08
`define SWG_OFS_FACTORY_B      8'h09
`define SWG_OFS_FACTORY_C      8'h0A
`define SWG_OFS_EDGE_PSAVE     8'h0B

// Reset values
`define SWG_RST_STORM_LOW      8'h4A
`define SWG_RST_FACTORY_A      8'h00
`define SWG_RST_FACTORY_B      8'h4C
`define SWG_RST_FACTORY_C      8'h00
`define SWG_RST_EDGE_PSAVE     8'h00
`define SWG_RD_UNMAPPED        8'h00

// Field positions in the edge / power-save register
`define SWG_BIT_P3_FALL        7
`define SWG_BIT_P4_FALL        6
`define SWG_BIT_PSAVE_DIS      3

// Storm measuring periods, in milliseconds, and the clock rate in kHz
`define SWG_PERIOD_100M_MS     50
`define SWG_PERIOD_10M_MS      500
`define SWG_CLK_KHZ            25000
`define SWG_PERIOD_100M_CYC    (`SWG_PERIOD_100M_MS * `SWG_CLK_KHZ)
`define SWG_PERIOD_10M_CYC     (`SWG_PERIOD_10M_MS * `SWG_CLK_KHZ)

`endif

// *** swg_pkg.sv ***
// Purpose: Types shared by the global control slice
// Assumes: 8-bit register data, 8-bit register address
// Notes:   Constants live in swg_map.svh
`default_nettype none

package swg_pkg;

    // One management register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } swg_reg_req_t;

    // Control levels that steer the MACs and PHYs
    typedef struct packed {
        logic        port3_reduced_mii_fall;
        logic        port4_reduced_mii_fall;
        logic        phy_power_save_dis;
        logic [10:0] storm_threshold;
    } swg_ctrl_t;

endpackage : swg_pkg

`default_nettype wire

// *** swg_storm_meter.sv ***
// Purpose: Per-port broadcast storm meter counting 64-byte blocks per measuring period
// Assumes: block_req is one pulse per 64-byte block of broadcast data offered
// Notes:   Period length follows the port speed at each compare
`timescale 1ns/1ps
`default_nettype none

module swg_storm_meter #(
    parameter int CNT_W = 24,
    parameter int P100  = 1250000,
    parameter int P10   = 12500000
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        port_10m,
    input  wire logic [10:0] threshold,
    input  wire logic        block_req,
    output logic             block_admit,
    output logic             block_drop
);

    localparam logic [CNT_W-1:0] LAST100 = CNT_W'(P100 - 1);
    localparam logic [CNT_W-1:0] LAST10  = CNT_W'(P10 - 1);

    logic [CNT_W-1:0] period_cnt_r;
    logic [10:0]      blk_cnt_r;
    logic [CNT_W-1:0] period_last;
    logic             period_end;

    // period by speed
    // Compare with >= so a speed change to 100M past the 100M length ends the period at once
    assign period_last = port_10m ? LAST10 : LAST100;
    assign period_end  = period_cnt_r >= period_last;

    assign block_admit = block_req && (blk_cnt_r < threshold);
    assign block_drop  = block_req && !block_admit;

    // Period timer and block count; a block admitted at the boundary opens the next period
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            period_cnt_r <= '0;
            blk_cnt_r    <= '0;
        end
        else
        begin
            period_cnt_r <= period_end ? '0 : period_cnt_r + 1'b1;
            if (period_end)
                blk_cnt_r <= block_admit ? 11'h001 : 11'h000;
            else if (block_admit)
                blk_cnt_r <= blk_cnt_r + 11'h001;
        end
    end

    // no growth at threshold
    // A lowered threshold may leave the count above it until the period ends, so only growth is barred
    admit_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n && !period_end && blk_cnt_r >= threshold |=> blk_cnt_r == $past(blk_cnt_r))
        else $error("storm block count grew past threshold");

    period_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        period_end && !block_admit |=> blk_cnt_r == 11'h000)
        else $error("block count not cleared at period end");

    period_len_a: assert property (@(posedge clk) disable iff (!rst_n)
        period_end && !port_10m && period_cnt_r == LAST100 |=> period_cnt_r == '0)
        else $error("100M period did not wrap at its length");

endmodule : swg_storm_meter

`default_nettype wire

// *** switch_global_control_regs_tb_top.sv ***
// Purpose: Self-checking bench for the global control slice and its storm meters
// Assumes: Storm periods shortened to 20 and 200 cycles
// Notes:   Random data from a fixed seed; a window of whole periods gives an exact admit count
`timescale 1ns/1ps
`default_nettype none
`include "swg_map.svh"

module switch_global_control_regs_tb_top;

    localparam int P100 = 20;
    localparam int P10  = 200;
    localparam int WIN  = 2000;

    logic                  clk;
    logic                  rst_n;
    swg_pkg::swg_reg_req_t req;
    logic [7:0]            rd_data;
    logic                  rd_valid;
    logic [2:0]            rate_hi;
    logic [3:0]            port_10m;
    logic [3:0]            blk_req;
    logic [3:0]            blk_admit;
    logic [3:0]            blk_drop;
    swg_pkg::swg_ctrl_t    ctrl;
    int                    n_errors;
    int                    checked;
    int                    admits [4];
    int                    drops [4];
    logic [7:0]            v;
    logic [7:0]            lo_val;
    logic [7:0]            fofs [3] = '{8'h08, 8'h09, 8'h0A};
    logic [7:0]            fexp [3] = '{8'h00, 8'h4C, 8'h00};

    swg_global_regs #(.NUM_PORTS(4), .CNT_W(24), .P100_CYC(P100), .P10_CYC(P10)) DUT (
        .clk(clk), .rst_n(rst_n), .reg_req(req), .rd_data(rd_data), .rd_valid(rd_valid),
        .storm_rate_hi(rate_hi), .port_10m(port_10m), .bcast_block_req(blk_req),
        .bcast_block_admit(blk_admit), .bcast_block_drop(blk_drop), .ctrl(ctrl));

    // Free-running 25 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // One comparison, four-state exact
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic print_verdict();
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    // Strobes held for exactly one sampled edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr    <= 1'b1;
        req.addr  <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge clk);
        req.rd   <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        chk(16'(rd_valid), 16'h0001, "read valid");
        chk(16'(rd_data), 16'(exp), msg);
    endtask : rd_chk

    // Whole periods in the window, so the phase of the window does not matter
    function automatic int exp_admits(input int thr, input int per);
        return (WIN / per) * ((thr < per) ? thr : per);
    endfunction : exp_admits

    // Only the two edge selects and the power-save bit are writable
    function automatic logic [7:0] edge_exp(input logic [7:0] d);
        return d & 8'hC8;
    endfunction : edge_exp

    // Ports 0,1 at 100 Mbps, ports 2,3 at 10 Mbps, all offering a block every cycle
    task automatic run_meter(input logic [2:0] hi, input logic [7:0] lo);
        rate_hi  <= hi;
        port_10m <= 4'hC;
        wr_reg(`SWG_OFS_STORM_LOW, lo);
        @(posedge clk);
        #1;
        chk(16'(ctrl.storm_threshold), 16'({hi, lo}), "threshold");
        @(posedge clk);
        blk_req <= 4'hF;
        admits = '{0, 0, 0, 0};
        drops  = '{0, 0, 0, 0};
        repeat (2 * P10) @(posedge clk);
        repeat (WIN)
        begin
            @(posedge clk);
            #1;
            chk(16'({blk_admit | blk_drop, blk_admit & blk_drop}), 16'({blk_req, 4'h0}), "admit/drop");
            for (int p = 0; p < 4; p++) admits[p] += int'(blk_admit[p]);
            for (int p = 0; p < 4; p++) drops[p] += int'(blk_drop[p]);
        end
        for (int p = 0; p < 4; p++)
        begin
            chk(16'(admits[p]), 16'(exp_admits(int'({hi, lo}), (p < 2) ? P100 : P10)), "admits");
            chk(16'(drops[p]), 16'(WIN - exp_admits(int'({hi, lo}), (p < 2) ? P100 : P10)), "drops");
        end
        @(posedge clk);
        blk_req <= 4'h0;
    endtask : run_meter

    // Watchdog, about seven times the expected run
    initial
    begin
        #2000000;
        n_errors++;
        print_verdict();
    end

    initial
    begin
        req = '0;
        rate_hi = 3'h0;
        port_10m = 4'h0;
        blk_req = 4'h0;
        rst_n = 1'b0;
        n_errors = 0;
        checked = 0;
        v = 8'($urandom(32'h1116c947));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int pass = 0; pass < 2; pass++)
        begin
            // reset values, also after a reset in mid-run
            rd_chk(`SWG_OFS_STORM_LOW, 8'h4A, "storm low reset");
            rd_chk(`SWG_OFS_EDGE_PSAVE, 8'h00, "edge reset");
            chk(16'({ctrl.port3_reduced_mii_fall, ctrl.port4_reduced_mii_fall, ctrl.phy_power_save_dis}),
                16'h0000, "ctrl reset");
            for (int i = 0; i < 3; i++)
            begin
                wr_reg(fofs[i], 8'($urandom));
                rd_chk(fofs[i], fexp[i], "factory");
            end
            wr_reg(8'h3F, 8'($urandom));
            rd_chk(8'h3F, 8'h00, "unmapped");
            // edge and power-save bits, corners then random
            for (int i = 0; i < 8; i++)
            begin
                v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
                wr_reg(`SWG_OFS_EDGE_PSAVE, v);
                rd_chk(`SWG_OFS_EDGE_PSAVE, edge_exp(v), "edge readback");
                chk(16'({ctrl.port3_reduced_mii_fall, ctrl.port4_reduced_mii_fall, ctrl.phy_power_save_dis}),
                    16'({v[7], v[6], v[3]}), "ctrl bits");
            end
            // Read and write in one cycle returns the old byte
            lo_val = 8'($urandom);
            @(posedge clk);
            req <= '{wr: 1'b1, rd: 1'b1, addr: `SWG_OFS_STORM_LOW, wdata: lo_val};
            @(posedge clk);
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            #1;
            chk(16'(rd_data), 16'h004A, "same-cycle read");
            rd_chk(`SWG_OFS_STORM_LOW, lo_val, "storm low write");
            @(posedge clk);
            rst_n <= 1'b0;
            @(posedge clk);
            rst_n <= 1'b1;
        end
        // threshold small, above the period, and zero
        run_meter(3'h0, 8'(1 + ($urandom % 15)));
        run_meter(3'h1, 8'($urandom));
        run_meter(3'h0, 8'h00);
        print_verdict();
    end

endmodule : switch_global_control_regs_tb_top

`default_nettype wire
